// *** hdl/rlp_crc16.sv ***
// Purpose: bitwise crc-16 register for the packet check
// Assumes: one data bit per enabled cycle
// Notes:   lsb-first bit order follows the on-air order
`timescale 1ns/1ns
module rlp_crc16
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        clear,   // preset the register
	input  wire logic        shift,   // absorb one bit
	input  wire logic        din,     // data bit
	output logic      [15:0] crc      // current remainder
);
	// shift in one bit per strobe
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			crc <= rlp_pkg::CRC_INIT;
		else if (clear)
			crc <= rlp_pkg::CRC_INIT;
		else if (shift)
			crc <= {crc[14:0], 1'b0} ^ ((crc[15] ^ din) ? rlp_pkg::CRC_POLY : 16'h0000);
	end
endmodule // rlp_crc16

// *** hdl/rlp_engine.sv ***
// Purpose: link-layer packet engine: frames, acks, retries, duplicates
// Assumes: one baseband bit per enabled cycle; modem outside this block
// Notes:   control and status are plain ports
// Summary of operation
// - channel above 39 is used as 39
// - transmit burst, then listen for acknowledge
// - host may write data during transfer
// - good ack: standby, clear start, set done
// - bad ack: retry below limit, else flag
// - matching packet answered with ack or nack
// - payload stored as received; good crc sets ready flag
// - stopping receive still accepts one packet
// - bytes lsb first, bits lsb first
// - preamble, address, flags, payload, crc order
// - preamble phase follows address lsb
// - preamble and address never reach host
// - flags hold tag, type, length fields
// - crc uses x16+x12+x5+1
// - ack is header plus crc; mismatch means nack
// - tag plus crc suppress duplicate delivery
// - status latches unmasked; mask gates irq
// - write one clears status bits
// - carrier is 2402 plus twice channel
`timescale 1ns/1ns
module rlp_engine
#(
	parameter int unsigned ACK_WAIT = rlp_pkg::ACK_WAIT_CYC
)
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,                       // freezes all state except the crc register when low
	input  wire logic [2:0]  target_peer_address,
	input  wire logic [2:0]  own_node_address,
	input  wire logic [5:0]  radio_channel_number,
	input  wire logic [7:0]  irq_mask_primary,
	input  wire logic [3:0]  retry_limit,
	input  wire logic        start_set,                // pulse: set the start bit
	input  wire logic        start_clear,              // pulse: host clears start
	input  wire logic        transmit_receive_select,  // 1 transmit, 0 receive
	input  wire logic [5:0]  transmit_payload_length,  // 1..32
	input  wire logic        tx_buf_we,                // transmit buffer write
	input  wire logic [4:0]  tx_buf_addr,
	input  wire logic [7:0]  tx_buf_wdata,
	input  wire logic [4:0]  rx_buf_addr,              // stored payload read index
	input  wire logic [7:0]  status_clear,             // write-one-to-clear
	input  wire logic        air_rx_bit,               // demodulated bit pin
	output logic             air_tx_bit,               // modulator data bit
	output logic             radio_tx_on,
	output logic             radio_rx_on,
	output logic [11:0]      carrier_mhz,
	output logic             start_bit,
	output logic [7:0]       irq_status_primary,
	output logic [7:0]       rx_buf_rdata,
	output logic [5:0]       rx_length,
	output logic             irq
);
	typedef enum logic [2:0] {RLP_IDLE, RLP_TX, RLP_WAIT_ACK, RLP_LISTEN, RLP_ACK_OUT} rlp_state_e;
	rlp_state_e   state;          // engine state
	logic [7:0]   tx_mem [32];    // transmit buffer, host writes any time
	logic [7:0]   rx_mem [32];    // stored received payload
	logic [7:0]   shreg;          // bit shift register
	logic [8:0]   bitcnt;         // bit count within the frame
	logic [15:0]  waitcnt;        // acknowledge timeout counter
	logic [3:0]   retries;        // retransmissions done
	logic [1:0]   tx_tag;         // packet sequence tag sent
	logic [1:0]   last_tag;       // last accepted received tag
	logic [15:0]  last_crc;       // crc of the last received packet
	logic [15:0]  sent_crc;       // crc of last sent packet
	logic [5:0]   frame_len;      // payload bytes in current frame
	logic [7:0]   rx_flags;
	logic [7:0]   rx_crc_lo;      // low byte of the received check
	logic [7:0]   rx_preamble;    // preamble expected for our own address
	logic [7:0]   hunt_pre;       // preamble searched for in the current state
	logic [8:0]   crc_at;         // bit count at which the check low byte is complete
	logic         crc_match;      // received check equals the expected one
	logic [15:0]  crc;
	logic         crc_clr;
	logic         crc_shift;
	logic         crc_bit;
	logic         rx_bit;         // synchronised air input
	logic         pkt_done;
	logic         tx_end;
	logic [5:0]   chan;
	logic [7:0]   preamble;
	logic [23:0]  tx_addr;
	logic [23:0]  my_addr;
	logic [8:0]   tx_bits;        // total bits of a frame to send
	logic [8:0]   hdr_bits;       // preamble+address+flags bits
	logic [7:0]   cur_byte;
	logic [7:0]   rx_shift;
	logic [23:0]  addr_shift;
	logic         ev_rx_dr;
	logic         ev_tx_ds;
	logic         ev_retry_limit_reached_flag;
	logic         rx_pending;     // one more packet allowed after stop

	localparam logic [8:0] HDR = 9'h028; // 8 preamble + 24 address + 8 flags bits

	// channel clamp and carrier frequency
	always_comb
	begin
		chan        = (radio_channel_number > rlp_pkg::CHAN_MAX) ? rlp_pkg::CHAN_MAX
		              : radio_channel_number;
		carrier_mhz = rlp_pkg::FREQ_BASE_MHZ + {5'h00, chan, 1'b0};
	end

	// addresses: fixed upper bytes, node bits in the low byte
	assign tx_addr  = {rlp_pkg::ADDR_PREFIX, rlp_pkg::ADDR_PREFIX, 5'h1C, target_peer_address};
	assign my_addr  = {rlp_pkg::ADDR_PREFIX, rlp_pkg::ADDR_PREFIX, 5'h1C, own_node_address};
	// preamble phase from the address lsb; shifted out lsb first
	assign preamble = tx_addr[0] ? rlp_pkg::PREAMBLE_LSB1 : rlp_pkg::PREAMBLE_LSB0;
	assign rx_preamble = my_addr[0] ? rlp_pkg::PREAMBLE_LSB1 : rlp_pkg::PREAMBLE_LSB0;
	// the ack comes back with the peer address, a data frame with ours
	assign hunt_pre = (state == RLP_LISTEN) ? rx_preamble : preamble;
	assign hdr_bits = HDR;
	assign tx_bits  = HDR + {frame_len, 3'b000} + 9'h010;

	rlp_sync3 u_sync
	(
		.clock (clock),
		.rst_n (rst_n),
		.ce    (ce),
		.din   (air_rx_bit),
		.dout  (rx_bit)
	);

	rlp_crc16 u_crc
	(
		.clock (clock),
		.rst_n (rst_n),
		.clear (crc_clr),
		.shift (crc_shift),
		.din   (crc_bit),
		.crc   (crc)
	);

	// byte being serialised: header field, payload, then crc, lsbyte first
	function automatic logic [7:0] frame_byte(input logic [5:0] idx, input logic [5:0] len,
		input logic [7:0] fl, input logic [7:0] pl, input logic [15:0] c);
		if (idx == 6'h00)
			frame_byte = fl;
		else if (idx <= len)
			frame_byte = pl;
		else if (idx == len + 6'h01)
			frame_byte = c[7:0];
		else
			frame_byte = c[15:8];
	endfunction

	// transmit bit selection: preamble, address, then byte stream lsb first
	always_comb
	begin
		logic [5:0] bidx;
		logic [7:0] fl;
		bidx     = 6'h00;
		fl       = {tx_tag, 1'b0, frame_len[4:0] - 5'h01};
		if (state == RLP_ACK_OUT)
			fl = {rx_flags[7:6], 1'b1, 5'h00};
		bidx     = 6'((bitcnt - 9'h020) >> 3);
		cur_byte = frame_byte(bidx, (state == RLP_ACK_OUT) ? 6'h00 : frame_len, fl,
			tx_mem[5'(bidx - 6'h01)], (state == RLP_ACK_OUT) ? rx_shift_crc() : crc);
		if (bitcnt < 9'h008)
			air_tx_bit = preamble[bitcnt[2:0]];
		else if (bitcnt < 9'h020)
			air_tx_bit = tx_addr[5'(bitcnt - 9'h008)];
		else
			air_tx_bit = cur_byte[bitcnt[2:0]];
	end

	// the ack carries back the crc just received so the sender can compare
	function automatic logic [15:0] rx_shift_crc();
		rx_shift_crc = last_crc;
	endfunction

	// crc feed: body bits only, from flags up to before the crc
	always_comb
	begin
		crc_clr   = (bitcnt == 9'h000);
		crc_shift = 1'b0;
		crc_bit   = 1'b0;
		if (state == RLP_TX && bitcnt >= hdr_bits - 9'h008 && bitcnt < tx_bits - 9'h010)
		begin
			crc_shift = 1'b1;
			crc_bit   = air_tx_bit;
		end
		else if (state == RLP_LISTEN && bitcnt >= hdr_bits - 9'h008
			&& bitcnt < hdr_bits + {frame_len, 3'b000})
		begin
			crc_shift = 1'b1;
			crc_bit   = rx_bit;
		end
	end

	assign tx_end   = (state == RLP_TX || state == RLP_ACK_OUT)
		&& bitcnt == ((state == RLP_ACK_OUT) ? HDR + 9'h00F : tx_bits - 9'h001);
	// after the hunt, rx_bit holds frame bit bitcnt and rx_shift the eight before it
	assign crc_at   = hdr_bits + ((state == RLP_LISTEN) ? {frame_len, 3'b000} : 9'h000)
		+ 9'h008;
	assign pkt_done = state == RLP_LISTEN && bitcnt == crc_at + 9'h007;
	assign crc_match = {rx_bit, rx_shift, rx_crc_lo[6:0]}
		== ((state == RLP_WAIT_ACK) ? sent_crc : crc);
	assign radio_tx_on = (state == RLP_TX) || (state == RLP_ACK_OUT);
	assign radio_rx_on = (state == RLP_WAIT_ACK) || (state == RLP_LISTEN);

	// receive shifting: address match, flags and payload bytes
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			addr_shift <= 24'h000000;
			rx_shift   <= 8'h00;
			rx_flags   <= 8'h00;
			rx_crc_lo  <= 8'h00;
		end
		else if (ce && radio_rx_on)
		begin
			rx_shift <= {rx_bit, rx_shift[7:1]};                         // lsb arrives first
			// the hunt edge already carries the first address bit
			if ((bitcnt >= 9'h008 && bitcnt < 9'h020)
				|| (bitcnt == 9'h000 && rx_shift == hunt_pre))
				addr_shift <= {rx_bit, addr_shift[23:1]};
			if (bitcnt == 9'h028)
				rx_flags <= rx_shift;
			if (bitcnt == crc_at)
				rx_crc_lo <= rx_shift;
		end
	end

	// payload store: only bytes after the address, never preamble
	always_ff @(posedge clock)
	begin
		if (ce && state == RLP_LISTEN && bitcnt > 9'h028 && bitcnt[2:0] == 3'h0
			&& bitcnt <= hdr_bits + {frame_len, 3'b000})
			rx_mem[5'((bitcnt - 9'h030) >> 3)] <= rx_shift;
		if (ce && tx_buf_we)
			tx_mem[tx_buf_addr] <= tx_buf_wdata;
	end

	// registered read of stored payload
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rx_buf_rdata <= 8'h00;
		else if (ce)
			rx_buf_rdata <= rx_mem[rx_buf_addr];
	end

	// main sequencer
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state      <= RLP_IDLE;
			bitcnt     <= 9'h000;
			waitcnt    <= 16'h0000;
			retries    <= 4'h0;
			tx_tag     <= 2'h0;
			last_tag   <= 2'h3;
			last_crc   <= 16'h0000;
			sent_crc   <= 16'h0000;
			frame_len  <= 6'h01;
			start_bit  <= 1'b0;
			rx_length  <= 6'h00;
			rx_pending <= 1'b0;
			ev_rx_dr   <= 1'b0;
			ev_tx_ds   <= 1'b0;
			ev_retry_limit_reached_flag  <= 1'b0;
		end
		else if (ce)
		begin
			ev_rx_dr  <= 1'b0;
			ev_tx_ds  <= 1'b0;
			ev_retry_limit_reached_flag <= 1'b0;
			if (start_set)
				start_bit <= 1'b1;
			else if (start_clear)
				start_bit <= 1'b0;
			unique case (state)
				RLP_IDLE:
				begin
					bitcnt <= 9'h000;
					if (start_set && transmit_receive_select)
					begin
						frame_len <= transmit_payload_length;
						retries   <= 4'h0;
						tx_tag    <= tx_tag + 2'h1;
						state     <= RLP_TX;
					end
					else if (start_set)
					begin
						rx_pending <= 1'b1;
						state      <= RLP_LISTEN;
					end
				end
				RLP_TX:
				begin
					bitcnt <= bitcnt + 9'h001;
					if (bitcnt == tx_bits - 9'h010)
						sent_crc <= crc;
					if (tx_end)
					begin
						bitcnt  <= 9'h000;
						waitcnt <= 16'h0000;
						state   <= RLP_WAIT_ACK;
					end
				end
				RLP_WAIT_ACK:
				begin
					waitcnt <= waitcnt + 16'h0001;
					if (bitcnt != 9'h000)
						bitcnt <= bitcnt + 9'h001;
					else if (rx_shift == hunt_pre)
						bitcnt <= 9'h009;                                    // preamble complete
					if (bitcnt == crc_at + 9'h007)
					begin
						if (crc_match)
						begin
							start_bit <= 1'b0;
							ev_tx_ds  <= 1'b1;
							state     <= RLP_IDLE;
						end
						else
							waitcnt <= 16'(ACK_WAIT);
						bitcnt <= 9'h000;
					end
					else if (waitcnt >= 16'(ACK_WAIT))
					begin
						bitcnt <= 9'h000;
						if (retries < retry_limit)
						begin
							retries <= retries + 4'h1;
							state   <= RLP_TX;
						end
						else
						begin
							ev_retry_limit_reached_flag <= 1'b1;
							start_bit <= 1'b0;
							state     <= RLP_IDLE;
						end
					end
				end
				RLP_LISTEN:
				begin
					if (bitcnt != 9'h000)
						bitcnt <= bitcnt + 9'h001;
					else if (rx_shift == hunt_pre)
						bitcnt <= 9'h009;                                    // preamble complete
					if (bitcnt == 9'h020 && addr_shift != my_addr)
						bitcnt <= 9'h000;                                    // not for us
					if (bitcnt == 9'h029)
						frame_len <= {1'b0, rx_flags[4:0]} + 6'h01;
					if (pkt_done)
					begin
						last_crc  <= crc;                                    // echoed
						bitcnt    <= 9'h000;
						// announce only new good packets: same tag and crc is a resend
						if (crc_match && !(rx_flags[7:6] == last_tag && crc == last_crc))
						begin
							last_tag  <= rx_flags[7:6];
							rx_length <= frame_len;
							ev_rx_dr  <= 1'b1;
						end
						state <= RLP_ACK_OUT;
					end
					else if (!start_bit && !rx_pending && bitcnt == 9'h000)
						state <= RLP_IDLE;
				end
				RLP_ACK_OUT:
				begin
					bitcnt <= bitcnt + 9'h001;
					if (tx_end)
					begin
						bitcnt     <= 9'h000;
						rx_pending <= start_bit;
						state      <= start_bit ? RLP_LISTEN : RLP_IDLE;
					end
				end
			endcase
		end
	end

	// sticky status, set wins over write-one-to-clear
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			irq_status_primary <= 8'h00;
		else if (ce)
			irq_status_primary <= (irq_status_primary & ~status_clear)
				| ({7'h00, ev_rx_dr} << rlp_pkg::ST_RX_DR)
				| ({7'h00, ev_tx_ds} << rlp_pkg::ST_TX_DS)
				| ({7'h00, ev_retry_limit_reached_flag} << rlp_pkg::ST_RETRY_LIMIT_REACHED_FLAG);
	end

	// mask only gates the pin
	assign irq = |(irq_status_primary & irq_mask_primary);

	// assertions
	property p_chan_clamp;
		@(posedge clock) disable iff (!rst_n)
		radio_channel_number > 6'h27 |-> carrier_mhz == 12'h9B0;
	endproperty
	a_chan_clamp: assert property (p_chan_clamp) else $error("channel not clamped");
	property p_irq_gate;
		@(posedge clock) disable iff (!rst_n)
		irq == |(irq_status_primary & irq_mask_primary);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq not masked status");
	property p_tx_done;
		@(posedge clock) disable iff (!rst_n)
		ce && ev_tx_ds |=> irq_status_primary[6] && !start_bit;
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("tx done not flagged");
	property p_rx_ready;
		@(posedge clock) disable iff (!rst_n)
		ce && ev_rx_dr |=> irq_status_primary[7];
	endproperty
	a_rx_ready: assert property (p_rx_ready) else $error("rx ready lost");
	property p_sticky;
		@(posedge clock) disable iff (!rst_n)
		ce && irq_status_primary[5] && !status_clear[5] |=> irq_status_primary[5];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit dropped");
	property p_maxrt_stop;
		@(posedge clock) disable iff (!rst_n)
		ce && ev_retry_limit_reached_flag |-> state == RLP_IDLE ##1 !radio_tx_on;
	endproperty
	a_maxrt_stop: assert property (p_maxrt_stop) else $error("kept sending at limit");
	property p_ack_after_rx;
		@(posedge clock) disable iff (!rst_n)
		ce && pkt_done |=> radio_tx_on;
	endproperty
	a_ack_after_rx: assert property (p_ack_after_rx) else $error("no ack sent");
	property p_preamble;
		@(posedge clock) disable iff (!rst_n)
		state == RLP_TX && bitcnt == 9'h000 |-> air_tx_bit == tx_addr[0];
	endproperty
	a_preamble: assert property (p_preamble) else $error("preamble phase wrong");
endmodule // rlp_engine

// *** hdl/rlp_sync3.sv ***
// Purpose: four-stage synchroniser for a pin input
// Assumes: input is asynchronous to clock
// Notes:   no agreement filter: the air stream may toggle on every cycle
`timescale 1ns/1ns
module rlp_sync3
(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic din,
	output logic      dout
);
	logic s1;  // metastable stage, read only by s2
	logic s2;
	logic s3;
	// capture chain, held while the clock enable is low
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1   <= 1'b0;
			s2   <= 1'b0;
			s3   <= 1'b0;
			dout <= 1'b0;
		end
		else if (ce)
		begin
			s1 <= din;
			s2 <= s1;
			s3   <= s2;
			dout <= s3;  // a stability filter would swallow one-cycle bits
		end
	end
endmodule // rlp_sync3

// *** inc/rlp_pkg.sv ***
// Purpose: shared constants for the radio link-layer packet engine
// Assumes: 100 MHz clock, one bit per cycle on the baseband stream
// Notes:   offsets, counts and reset values live here
package rlp_pkg;
	localparam int unsigned CLK_MHZ          = 100;           // system clock rate
	localparam int unsigned ACK_WAIT_US      = 200;           // acknowledge wait time in us
	localparam int unsigned ACK_WAIT_CYC     = ACK_WAIT_US * CLK_MHZ; // cycles of ack wait
	localparam logic [5:0]  CHAN_MAX         = 6'h27;         // highest channel, 39
	localparam logic [11:0] FREQ_BASE_MHZ    = 12'h962;       // 2402 MHz base frequency
	localparam logic [15:0] CRC_POLY         = 16'h1021;      // x^16 + x^12 + x^5 + 1
	localparam logic [15:0] CRC_INIT         = 16'hFFFF;      // crc preset
	localparam logic [7:0]  PREAMBLE_LSB0    = 8'hAA;         // sent lsb first: 0,1,0,1..
	localparam logic [7:0]  PREAMBLE_LSB1    = 8'h55;         // sent lsb first: 1,0,1,0..
	localparam int unsigned ADDR_BYTES       = 3;             // address length in bytes
	localparam int unsigned MAX_PAYLOAD      = 32;            // largest payload in bytes
	localparam int unsigned FLG_PID_LSB      = 6;             // packet tag field position
	localparam int unsigned FLG_TYPE_BIT     = 5;             // packet type bit
	localparam int unsigned FLG_LEN_LSB      = 0;             // length code position
	localparam logic [3:0]  RETRY_MAX_RESET  = 4'h3;          // default retry limit
	localparam logic [7:0]  ADDR_PREFIX      = 8'hE7;         // upper address bytes
	// status flag positions
	localparam int unsigned ST_RX_DR  = 7;
	localparam int unsigned ST_TX_DS  = 6;
	localparam int unsigned ST_RETRY_LIMIT_REACHED_FLAG = 5;
	localparam int unsigned ST_XM_END = 0;
	typedef enum logic [1:0] {RLP_RX_SEND_ACK, RLP_RX_SEND_NACK, RLP_TX_DATA, RLP_TX_NONE} rlp_kind_e;
endpackage

// *** verification/rlp_peer_model.sv ***
// Purpose: far radio of the link; answers each burst with an acknowledge frame unless set silent
// Assumes: one bit per clock on both air lines; ce held high
// Notes:   the reply echoes header and check bits, so it is a good ack unless reply_mode asks for a nack
`timescale 1ns/1ns
module rlp_peer_model
(
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       air_tx_bit,
	input  wire logic       radio_tx_on,
	input  wire logic       radio_rx_on,
	input  wire logic [1:0] reply_mode,  // 0 ack, 1 nack, 2 silent
	output logic            air_rx_bit
);
	logic heard[$];  // bits of the burst just received
	logic reply[$];  // bits still to send back
	logic was_tx;    // burst seen last cycle
	logic parked;    // line already left at the inverse of the last bit
	int   gap;       // turnaround cycles before replying
	int   n;         // length of the heard burst
	// capture each burst, then replay header and check bits once the block listens
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			heard.delete();
			reply.delete();
			was_tx <= 1'b0;
			parked <= 1'b1;
			gap = 0;
			air_rx_bit <= 1'b0;
		end
		else
		begin
			was_tx <= radio_tx_on;
			if (radio_tx_on)
				heard.push_back(air_tx_bit);
			else if (was_tx)
			begin
				n = heard.size();
				// ack is preamble, address, flags and the check echoed back
				if (reply_mode != 2'h2 && n >= 56)
				begin
					for (int i = 0; i < 40; i++)
						reply.push_back(heard[i]);
					// a nack differs only in the last check bit
					for (int i = n - 16; i < n; i++)
						reply.push_back(heard[i] ^ (reply_mode == 2'h1 && i == n - 1));
				end
				heard.delete();
				gap = 4;
			end
			else if (reply.size() != 0 && radio_rx_on)
			begin
				// a short turnaround keeps the block honest about its listen window
				if (gap != 0)
					gap--;
				else
				begin
					air_rx_bit <= reply.pop_front();
					parked <= 1'b0;
				end
			end
			else if (!parked)
			begin
				// released line must not keep showing the last bit
				air_rx_bit <= ~air_rx_bit;
				parked <= 1'b1;
			end
		end
	end
endmodule // rlp_peer_model

// *** verification/tb_rlp_engine.sv ***
// Purpose: self-checking bench for the packet engine
// Assumes: ack wait shortened to 200 cycles; peer model answers on air
// Notes:   receive path is left to the in-design assertions for lack of room
`timescale 1ns/1ns
module tb_rlp_engine;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  target_peer_address = 3'h0;
	logic [2:0]  own_node_address = 3'h2;
	logic [5:0]  radio_channel_number = 6'h00;
	logic [7:0]  irq_mask_primary = 8'h00;
	logic [3:0]  retry_limit = 4'h2;
	logic        start_set = 1'b0;
	logic        start_clear = 1'b0;
	logic        transmit_receive_select = 1'b1;
	logic [5:0]  transmit_payload_length = 6'h01;
	logic        tx_buf_we = 1'b0;
	logic [4:0]  tx_buf_addr = 5'h00;
	logic [7:0]  tx_buf_wdata = 8'h00;
	logic [7:0]  status_clear = 8'h00;
	logic [1:0]  reply_mode = 2'h0;
	logic        air_rx_bit, air_tx_bit, radio_tx_on, radio_rx_on, start_bit, irq;
	logic [11:0] carrier_mhz;
	logic [7:0]  irq_status_primary, rx_buf_rdata;
	logic [5:0]  rx_length;
	int          mismatches = 0;
	int          comparisons = 0;
	// free-running 100 MHz clock
	always #5 clock = ~clock;
	rlp_engine #(.ACK_WAIT(200)) u_rlp_engine (.clock(clock), .rst_n(rst_n), .ce(1'b1),
		.target_peer_address(target_peer_address), .own_node_address(own_node_address),
		.radio_channel_number(radio_channel_number), .irq_mask_primary(irq_mask_primary),
		.retry_limit(retry_limit), .start_set(start_set), .start_clear(start_clear),
		.transmit_receive_select(transmit_receive_select),
		.transmit_payload_length(transmit_payload_length), .tx_buf_we(tx_buf_we),
		.tx_buf_addr(tx_buf_addr), .tx_buf_wdata(tx_buf_wdata), .rx_buf_addr(5'h00),
		.status_clear(status_clear), .air_rx_bit(air_rx_bit), .air_tx_bit(air_tx_bit),
		.radio_tx_on(radio_tx_on), .radio_rx_on(radio_rx_on), .carrier_mhz(carrier_mhz),
		.start_bit(start_bit), .irq_status_primary(irq_status_primary),
		.rx_buf_rdata(rx_buf_rdata), .rx_length(rx_length), .irq(irq));
	rlp_peer_model u_rlp_peer_model (.clock(clock), .rst_n(rst_n), .air_tx_bit(air_tx_bit),
		.radio_tx_on(radio_tx_on), .radio_rx_on(radio_rx_on), .reply_mode(reply_mode),
		.air_rx_bit(air_rx_bit));
	// one comparison, counted and reported
	task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp)
		begin
			$display("unexpected %s: expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask
	// the single place where the run ends
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one-cycle start pulse, transmit unless sel is 0
	task automatic start_tx(input logic sel = 1'b1);
		@(posedge clock);
		transmit_receive_select <= sel;
		start_set <= 1'b1;
		@(posedge clock);
		start_set <= 1'b0;
	endtask
	// write-one-to-clear a status bit, then look at it settled
	task automatic clear_flags(input logic [7:0] bits);
		@(posedge clock);
		status_clear <= bits;
		@(posedge clock);
		status_clear <= 8'h00;
		@(negedge clock);
		check("status after clear", 64'h0, {56'h0, irq_status_primary});
	endtask
	// channel clamp and carrier frequency for edge values
	task automatic chan_test();
		logic [5:0] chans[4] = '{6'h00, 6'h27, 6'h28, 6'h3F};
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clock);
			radio_channel_number <= chans[i];
			@(negedge clock);
			check("carrier", 64'd2402 + 2 * ((chans[i] > 6'h27) ? 39 : chans[i]), {52'h0, carrier_mhz});
		end
	endtask
	// good ack: frame layout on air, done flag, start cleared, irq through mask
	task automatic tx_ok(input logic [2:0] peer, input logic [7:0] data);
		logic [47:0] exp;
		logic [47:0] got;
		logic [47:0] care;
		int          k;
		@(posedge clock);
		target_peer_address <= peer; // no long zero runs in these addresses
		irq_mask_primary <= 8'h40;
		reply_mode <= 2'h0;
		tx_buf_we <= 1'b1;
		tx_buf_wdata <= data;
		@(posedge clock);
		tx_buf_we <= 1'b0;
		// preamble, address low byte first, flags, payload, every byte lsb first
		exp = {data, 3'h0, 5'h00, 8'hE7, 8'hE7, 5'h1C, peer, peer[0] ? 8'h55 : 8'hAA};
		care = {8'hFF, 8'h1F, 32'hFFFF_FFFF};
		start_tx();
		k = 0;
		while (!radio_tx_on && k < 50)
		begin
			@(negedge clock);
			k++;
		end
		if (k >= 50)
			mismatches++;
		for (int i = 0; i < 48; i++)
		begin
			got[i] = air_tx_bit;
			@(negedge clock);
		end
		check("frame head", exp & care, got & care);
		k = 0;
		while (start_bit !== 1'b0 && k < 2000)
		begin
			@(negedge clock);
			k++;
		end
		if (k >= 2000)
			mismatches++;
		// the done flag lands one edge after start drops
		@(negedge clock);
		check("start bit after ack", 64'h0, {63'h0, start_bit});
		check("status after ack", 64'h40, {56'h0, irq_status_primary});
		check("irq unmasked", 64'h1, {63'h0, irq});
		clear_flags(8'h40);
		check("irq after clear", 64'h0, {63'h0, irq});
	endtask
	// nack or silence: limited resends, then retry flag with irq masked
	task automatic tx_fail(input logic [1:0] mode);
		int  bursts;
		int  k;
		logic prev;
		@(posedge clock);
		reply_mode <= mode;
		irq_mask_primary <= 8'h00;
		retry_limit <= 4'h2;
		start_tx();
		@(posedge clock);
		tx_buf_addr <= 5'h01; // host keeps writing mid-transfer
		tx_buf_we <= 1'b1;
		@(posedge clock);
		tx_buf_we <= 1'b0;
		tx_buf_addr <= 5'h00;
		bursts = 0;
		prev = 1'b0;
		k = 0;
		while (irq_status_primary[5] !== 1'b1 && k < 5000)
		begin
			@(negedge clock);
			if (radio_tx_on && !prev)
				bursts++;
			prev = radio_tx_on;
			k++;
		end
		if (k >= 5000)
			mismatches++;
		check("bursts", 64'd3, bursts);
		check("status at limit", 64'h20, {56'h0, irq_status_primary});
		check("irq masked", 64'h0, {63'h0, irq});
		clear_flags(8'h20);
	endtask
	// receive start, then stop: listening goes on for one more packet
	task automatic rx_test();
		start_tx(1'b0);
		@(negedge clock);
		check("listening", 64'h1, {63'h0, radio_rx_on});
		@(posedge clock);
		start_clear <= 1'b1;
		@(posedge clock);
		start_clear <= 1'b0;
		@(negedge clock);
		check("start bit after stop", 64'h0, {63'h0, start_bit});
		check("still listening", 64'h1, {63'h0, radio_rx_on});
		check("no length yet", 64'h0, {58'h0, rx_length});
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge clock);
		rst_n <= 1'b1; // awake from reset, no sleep exit needed
		@(negedge clock);
		check("idle outputs", 64'h0, {radio_tx_on, radio_rx_on, start_bit, irq, irq_status_primary});
		chan_test();
		tx_ok(3'h5, 8'hA5);
		tx_ok(3'h2, 8'h3C);
		tx_fail(2'h1);
		tx_fail(2'h2);
		rx_test();
		stop_test();
	end
	// cuts a hang short
	initial
	begin
		#900000;
		mismatches++;
		stop_test();
	end
endmodule // tb_rlp_engine
